//--- xosc_pkg.sv
// Package for the crystal oscillator control block: offsets, fields, reset values
package xosc_pkg;
  // Register byte offsets
  localparam logic [11:0] FAST_CTL_OFS  = 12'h000;
  localparam logic [11:0] SLOW_CTL_OFS  = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS  = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h00c;
  // Control register field positions
  localparam int BYP_BIT     = 31;
  localparam int ECNT_LSB    = 16;
  localparam int MASK_BIT    = 15;
  localparam int PEND_BIT    = 7;
  localparam int STAT_BIT    = 6;
  localparam int PWR_BIT     = 5;
  localparam int DIV_LSB     = 0;
  // Reset values
  localparam logic [7:0] ECNT_RST  = 8'h80;
  localparam logic [4:0] DIV_RST   = 5'h00;
  // Stabilization counter granularity: end count is end_count_value shifted left by this
  localparam int STAB_SHIFT  = 9;
  localparam int STAB_W      = 8 + STAB_SHIFT;
  // Three-flop input synchroniser depth
  localparam int SYNC_DEPTH  = 3;

  // Software configuration of one oscillator
  typedef struct packed {
    logic       bypass_select;
    logic [7:0] end_count_value;
    logic [4:0] output_divider;
  } osc_cfg_s;

  // Oscillator stabilization state
  typedef enum logic [1:0] {
    OSC_OFF    = 2'b00,
    OSC_COUNT  = 2'b01,
    OSC_STABLE = 2'b11,
    OSC_BYPASS = 2'b10
  } osc_state_e;
endpackage

//--- crystal_oscillator_control.sv
// Crystal oscillator control: power, stabilization, bypass, divider, ready interrupt, APB slave
// Contract
// - Reset leaves both crystal oscillators powered down until switched on.
// - Switching an oscillator on from off starts a counter; its clock is released at end_count_value times 512.
// - The fast oscillator sets its ready-pending flag when its count reaches the end value.
// - The fast ready interrupt is high only while ready-pending is set and the mask is 1; irq also goes high on the slow pending flag under its mask.
// - Writing 1 to the fast ready-pending flag clears it; writing 0 leaves it.
// - The fast oscillator is powered by the mode-entry manager's enable for the active mode.
// - Fast clock availability is reported as a global status output.
// - Bypass can be set by software but only a system reset clears it.
// - In bypass the input pin clock passes with the same polarity and status reads 1.
// - Bypass acts regardless of the power-on control.
// - The stabilization counter is held in reset while bypass is selected.
// - Without bypass the oscillator output is the root clock; with bypass the input pin is.
// - Each output clock is divided by the divider field plus one, 1 to 32.
// - The slow oscillator is switched by its own power-on bit: 0 off, 1 on.
// - The slow stable bit reads 0 until the count reaches the end value times 512, then 1.
`timescale 1ns/10ps

module crystal_oscillator_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode-entry manager
  input  wire logic        fast_osc_mode_enable,
  output logic             fast_osc_global_status,
  // Oscillator pins (sampled clocks from the crystal circuits)
  input  wire logic        crystal_input_pin,
  input  wire logic        slow_crystal_input_pin,
  output logic             fast_osc_power_en,
  output logic             slow_osc_power_en,
  // Divided oscillator clocks and interrupt
  output logic             fast_osc_clk_out,
  output logic             slow_osc_clk_out,
  output logic             irq
);

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic       srst_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_q[1];

  // Configuration registers
  xosc_pkg::osc_cfg_s fast_cfg_q;
  xosc_pkg::osc_cfg_s slow_cfg_q;
  logic               fast_mask_q;
  logic               slow_power_on_q;
  logic               fast_pend_q;
  logic               slow_pend_q;
  logic               slow_mask_q;

  // Bus decode
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Pin clocks pass three flops; an edge counts once stages two and three agree
  logic [xosc_pkg::SYNC_DEPTH-1:0] fast_pin_q;
  logic [xosc_pkg::SYNC_DEPTH-1:0] slow_pin_q;
  logic                            fast_lvl_q;
  logic                            slow_lvl_q;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fast_pin_q <= '0;
      slow_pin_q <= '0;
      fast_lvl_q <= 1'b0;
      slow_lvl_q <= 1'b0;
    end else begin
      fast_pin_q <= {fast_pin_q[1:0], crystal_input_pin};
      slow_pin_q <= {slow_pin_q[1:0], slow_crystal_input_pin};
      if (fast_pin_q[1] == fast_pin_q[2]) begin
        fast_lvl_q <= fast_pin_q[2];
      end
      if (slow_pin_q[1] == slow_pin_q[2]) begin
        slow_lvl_q <= slow_pin_q[2];
      end
    end
  end

  // Rising edges of the oscillator clocks act as count enables
  logic fast_lvl_d1_q;
  logic slow_lvl_d1_q;
  logic fast_rise;
  logic slow_rise;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fast_lvl_d1_q <= 1'b0;
      slow_lvl_d1_q <= 1'b0;
    end else begin
      fast_lvl_d1_q <= fast_lvl_q;
      slow_lvl_d1_q <= slow_lvl_q;
    end
  end
  assign fast_rise = fast_lvl_q && !fast_lvl_d1_q;
  assign slow_rise = slow_lvl_q && !slow_lvl_d1_q;

  // Power controls
  logic fast_on;
  logic slow_on;
  assign fast_on = fast_osc_mode_enable;
  assign slow_on = slow_power_on_q;

  // Stabilization and divider per oscillator
  logic fast_stable;
  logic slow_stable;
  logic fast_done;
  logic slow_done;
  logic fast_div_clk;
  logic slow_div_clk;

  osc_channel u_fast (
    .clk      (clk),
    .srst_n   (srst_n),
    .power_on (fast_on),
    .cfg      (fast_cfg_q),
    .osc_rise (fast_rise),
    .osc_lvl  (fast_lvl_q),
    .stable   (fast_stable),
    .done     (fast_done),
    .div_clk  (fast_div_clk)
  );

  osc_channel u_slow (
    .clk      (clk),
    .srst_n   (srst_n),
    .power_on (slow_on),
    .cfg      (slow_cfg_q),
    .osc_rise (slow_rise),
    .osc_lvl  (slow_lvl_q),
    .stable   (slow_stable),
    .done     (slow_done),
    .div_clk  (slow_div_clk)
  );

  // Control register writes; bypass is sticky until reset
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fast_cfg_q      <= '{1'b0, xosc_pkg::ECNT_RST, xosc_pkg::DIV_RST};
      slow_cfg_q      <= '{1'b0, xosc_pkg::ECNT_RST, xosc_pkg::DIV_RST};
      fast_mask_q     <= 1'b0;
      slow_mask_q     <= 1'b0;
      slow_power_on_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == xosc_pkg::FAST_CTL_OFS) begin
        fast_cfg_q.bypass_select   <= fast_cfg_q.bypass_select | pwdata[xosc_pkg::BYP_BIT];
        fast_cfg_q.end_count_value <= pwdata[xosc_pkg::ECNT_LSB +: 8];
        fast_cfg_q.output_divider  <= pwdata[xosc_pkg::DIV_LSB +: 5];
        fast_mask_q                <= pwdata[xosc_pkg::MASK_BIT];
      end
      if (paddr == xosc_pkg::SLOW_CTL_OFS) begin
        slow_cfg_q.bypass_select   <= slow_cfg_q.bypass_select | pwdata[xosc_pkg::BYP_BIT];
        slow_cfg_q.end_count_value <= pwdata[xosc_pkg::ECNT_LSB +: 8];
        slow_cfg_q.output_divider  <= pwdata[xosc_pkg::DIV_LSB +: 5];
        slow_power_on_q            <= pwdata[xosc_pkg::PWR_BIT];
      end
      if (paddr == xosc_pkg::IRQ_MASK_OFS) begin
        fast_mask_q <= pwdata[0];
        slow_mask_q <= pwdata[1];
      end
    end
  end

  // Pending flags: hardware set wins over a same-cycle write-one clear
  logic fast_clr;
  logic slow_clr;
  assign fast_clr = wr_en && (((paddr == xosc_pkg::FAST_CTL_OFS) && pwdata[xosc_pkg::PEND_BIT]) ||
                              ((paddr == xosc_pkg::IRQ_STAT_OFS) && pwdata[0]));
  assign slow_clr = wr_en && (paddr == xosc_pkg::IRQ_STAT_OFS) && pwdata[1];
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fast_pend_q <= 1'b0;
      slow_pend_q <= 1'b0;
    end else begin
      if (fast_done) begin
        fast_pend_q <= 1'b1;
      end else if (fast_clr) begin
        fast_pend_q <= 1'b0;
      end
      if (slow_done) begin
        slow_pend_q <= 1'b1;
      end else if (slow_clr) begin
        slow_pend_q <= 1'b0;
      end
    end
  end

  // Read mux, sampled in the setup cycle so data stands in the access phase
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      xosc_pkg::FAST_CTL_OFS: begin
        rd_d[xosc_pkg::BYP_BIT]         = fast_cfg_q.bypass_select;
        rd_d[xosc_pkg::ECNT_LSB +: 8]   = fast_cfg_q.end_count_value;
        rd_d[xosc_pkg::MASK_BIT]        = fast_mask_q;
        rd_d[xosc_pkg::PEND_BIT]        = fast_pend_q;
        rd_d[xosc_pkg::STAT_BIT]        = fast_stable;
        rd_d[xosc_pkg::PWR_BIT]         = fast_on;
        rd_d[xosc_pkg::DIV_LSB +: 5]    = fast_cfg_q.output_divider;
      end
      xosc_pkg::SLOW_CTL_OFS: begin
        rd_d[xosc_pkg::BYP_BIT]         = slow_cfg_q.bypass_select;
        rd_d[xosc_pkg::ECNT_LSB +: 8]   = slow_cfg_q.end_count_value;
        rd_d[xosc_pkg::STAT_BIT]        = slow_stable;
        rd_d[xosc_pkg::PWR_BIT]         = slow_power_on_q;
        rd_d[xosc_pkg::DIV_LSB +: 5]    = slow_cfg_q.output_divider;
      end
      xosc_pkg::IRQ_STAT_OFS: rd_d[1:0] = {slow_pend_q, fast_pend_q};
      xosc_pkg::IRQ_MASK_OFS: rd_d[1:0] = {slow_mask_q, fast_mask_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait-free access phase, unmapped addresses flag an error
  logic mapped;
  assign mapped = (paddr == xosc_pkg::FAST_CTL_OFS) || (paddr == xosc_pkg::SLOW_CTL_OFS) ||
                  (paddr == xosc_pkg::IRQ_STAT_OFS) || (paddr == xosc_pkg::IRQ_MASK_OFS);
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= rd_d;
      end
    end
  end

  // Registered outputs: status, power, clocks, interrupt
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fast_osc_global_status <= 1'b0;
      fast_osc_power_en      <= 1'b0;
      slow_osc_power_en      <= 1'b0;
      fast_osc_clk_out       <= 1'b0;
      slow_osc_clk_out       <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      fast_osc_global_status <= fast_stable;
      // Analog core stays off in bypass, power control no matter
      fast_osc_power_en      <= fast_on && !fast_cfg_q.bypass_select;
      slow_osc_power_en      <= slow_on && !slow_cfg_q.bypass_select;
      fast_osc_clk_out       <= fast_div_clk;
      slow_osc_clk_out       <= slow_div_clk;
      irq                    <= (fast_pend_q && fast_mask_q) || (slow_pend_q && slow_mask_q);
    end
  end

endmodule

// One oscillator channel: stabilization counter, root clock select, divider
module osc_channel (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               srst_n,
  // Control
  input  wire logic               power_on,
  input  wire xosc_pkg::osc_cfg_s cfg,
  input  wire logic               osc_rise,
  input  wire logic               osc_lvl,
  // Status and clock
  output logic                    stable,
  output logic                    done,
  output logic                    div_clk
);

  xosc_pkg::osc_state_e            state_q;
  logic [xosc_pkg::STAB_W-1:0]     cnt_q;
  logic [xosc_pkg::STAB_W-1:0]     end_cnt;
  logic [4:0]                      div_cnt_q;
  logic                            div_q;
  logic                            root_rise;

  // End count is end_count_value shifted by nine
  assign end_cnt = {cfg.end_count_value, {xosc_pkg::STAB_SHIFT{1'b0}}};

  // Counter state; it counts oscillator edges as enables, but runs on the system clock
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_q <= xosc_pkg::OSC_OFF;
      cnt_q   <= '0;
    end else if (cfg.bypass_select) begin
      state_q <= xosc_pkg::OSC_BYPASS;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        xosc_pkg::OSC_OFF: begin
          cnt_q <= '0;
          if (power_on) begin
            state_q <= xosc_pkg::OSC_COUNT;
          end
        end
        xosc_pkg::OSC_COUNT: begin
          if (!power_on) begin
            state_q <= xosc_pkg::OSC_OFF;
          end else if (cnt_q >= end_cnt) begin
            state_q <= xosc_pkg::OSC_STABLE;
          end else if (osc_rise) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        xosc_pkg::OSC_STABLE: begin
          if (!power_on) begin
            state_q <= xosc_pkg::OSC_OFF;
          end
        end
        xosc_pkg::OSC_BYPASS: state_q <= xosc_pkg::OSC_BYPASS;
      endcase
    end
  end

  // Available only once stable or while bypassed, in which status is forced to 1
  assign stable = (state_q == xosc_pkg::OSC_STABLE) || (state_q == xosc_pkg::OSC_BYPASS);
  assign done   = (state_q == xosc_pkg::OSC_COUNT) && power_on && (cnt_q >= end_cnt) &&
                  !cfg.bypass_select;
  // Root clock is the pin in bypass, the gated oscillator otherwise
  assign root_rise = osc_rise && stable;

  // Divide by output_divider+1; factor 1 passes the level with its own polarity
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      div_cnt_q <= 5'h00;
      div_q     <= 1'b0;
    end else if (!stable) begin
      div_cnt_q <= 5'h00;
      div_q     <= 1'b0;
    end else if (root_rise) begin
      if (div_cnt_q >= cfg.output_divider) begin
        div_cnt_q <= 5'h00;
        div_q     <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 5'h01;
        div_q     <= 1'b0;
      end
    end else if (!osc_lvl) begin
      div_q <= 1'b0;
    end
  end
  assign div_clk = (cfg.output_divider == 5'h00) ? (stable && osc_lvl) : div_q;

endmodule

//--- xosc_crystal_source.sv
// Behavioural crystal and external clock sources on the two oscillator pins
`timescale 1ns/10ps

module xosc_crystal_source #(
  parameter real FAST_HALF = 20.0,
  parameter real SLOW_HALF = 32.0
) (
  // Run requests: analog enable or bypass clock applied
  input  wire logic fast_run,
  input  wire logic slow_run,
  // Pin clocks
  output logic      fast_pin,
  output logic      slow_pin
);
  // Fast source stands still low while nothing powers or bypasses it
  always begin
    if (fast_run === 1'b1) begin
      #FAST_HALF fast_pin = ~fast_pin;
    end else begin
      fast_pin = 1'b0;
      @(fast_run);
    end
  end

  // Slow source, same behaviour with a longer period
  always begin
    if (slow_run === 1'b1) begin
      #SLOW_HALF slow_pin = ~slow_pin;
    end else begin
      slow_pin = 1'b0;
      @(slow_run);
    end
  end
endmodule

//--- xosc_checker.sv
// Port-level assertions for the crystal oscillator control block
`timescale 1ns/10ps

module xosc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fast_osc_mode_enable,
  input wire logic fast_osc_global_status,
  input wire logic fast_osc_power_en,
  input wire logic slow_osc_power_en,
  input wire logic fast_osc_clk_out,
  input wire logic slow_osc_clk_out,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_quiet: assert property ($rose(rst_n) |-> !fast_osc_power_en && !slow_osc_power_en && !irq)
    else $error("oscillator active right after reset");
  chk_fast_settle: assert property ($rose(fast_osc_power_en) |=> !fast_osc_global_status [*8])
    else $error("fast status too early after power on");
  chk_slow_settle: assert property ($rose(slow_osc_power_en) |=> !slow_osc_clk_out [*8])
    else $error("slow clock released too early");
  chk_mode_off: assert property ($fell(fast_osc_mode_enable) |-> ##[0:4] !fast_osc_power_en)
    else $error("fast oscillator not powered down");
  chk_mode_on: assert property ($rose(fast_osc_mode_enable) && !fast_osc_global_status |-> ##[1:4] fast_osc_power_en)
    else $error("fast oscillator not powered up");
  chk_dead_clk: assert property (!fast_osc_global_status && !$past(fast_osc_global_status, 2) |-> !fast_osc_clk_out)
    else $error("fast clock runs while unavailable");
  chk_bypass_hold: assert property (fast_osc_global_status && !fast_osc_power_en && fast_osc_mode_enable |=> fast_osc_global_status)
    else $error("bypass status dropped");
  chk_ready_time: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  chk_ready_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

// Attach to every instance of the block
bind crystal_oscillator_control xosc_checker u_xosc_checker (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .fast_osc_mode_enable(fast_osc_mode_enable), .fast_osc_global_status(fast_osc_global_status),
  .fast_osc_power_en(fast_osc_power_en), .slow_osc_power_en(slow_osc_power_en),
  .fast_osc_clk_out(fast_osc_clk_out), .slow_osc_clk_out(slow_osc_clk_out), .irq(irq));

//--- tb.sv
// Self-checking testbench for the crystal oscillator control block
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
  logic        clk, rst_n, psel, penable, pwrite, mode_en, byp_f, byp_s, pready, pslverr;
  logic        gstat, fpwr, spwr, fclk, sclk, irq, fpin, spin, pf, po;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [64:0] expq[$];
  logic [64:0] note;
  int          error_cnt, check_count, cyc, n, cnt, div;

  crystal_oscillator_control u_crystal_oscillator_control (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_osc_mode_enable(mode_en), .fast_osc_global_status(gstat),
    .crystal_input_pin(fpin), .slow_crystal_input_pin(spin), .fast_osc_power_en(fpwr),
    .slow_osc_power_en(spwr), .fast_osc_clk_out(fclk), .slow_osc_clk_out(sclk), .irq(irq));
  xosc_crystal_source u_xosc_crystal_source (.fast_run(fpwr | byp_f), .slow_run(spwr | byp_s),
    .fast_pin(fpin), .slow_pin(spin));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Read monitor takes the oldest note at each read completion
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      note = expq.pop_front();
      `CHK({pslverr, prdata & note[63:32]}, {note[64], note[31:0]})
    end
  end

  // Hang guard, far above the expected run of at most about 16500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  task conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; request held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic err);
    expq.push_back({err, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Control word from its fields
  function automatic logic [31:0] ctl(logic b, logic [7:0] e, logic m, logic p, logic w, logic [4:0] d);
    ctl = (32'(b) << xosc_pkg::BYP_BIT) | (32'(e) << xosc_pkg::ECNT_LSB) | (32'(m) << xosc_pkg::MASK_BIT)
        | (32'(p) << xosc_pkg::PEND_BIT) | (32'(w) << xosc_pkg::PWR_BIT) | (32'(d) << xosc_pkg::DIV_LSB);
  endfunction

  // Counts output rises over a number of fast pin rises
  task measure(input int edges);
    pf = fpin; po = fclk; n = 0; cnt = 0;
    while (n < edges) begin
      @(posedge clk);
      n += int'(fpin && !pf);
      cnt += int'(fclk && !po);
      pf = fpin; po = fclk;
    end
  endtask

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    mode_en = 1'b0; byp_f = 1'b0; byp_s = 1'b0; error_cnt = 0; check_count = 0; cyc = 0;
    void'($urandom(82));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(xosc_pkg::FAST_CTL_OFS, 32'h80ff00ff, ctl(0, xosc_pkg::ECNT_RST, 0, 0, 0, xosc_pkg::DIV_RST), 0);
    rd(xosc_pkg::SLOW_CTL_OFS, 32'h80ff00ff, ctl(0, xosc_pkg::ECNT_RST, 0, 0, 0, xosc_pkg::DIV_RST), 0);
    rd(12'h010, 32'hffffffff, 32'h0, 1);
    // Fast start-up with a short end count and the ready interrupt enabled
    wr(xosc_pkg::FAST_CTL_OFS, ctl(0, 1, 1, 0, 0, 0));
    wr(xosc_pkg::IRQ_MASK_OFS, 32'h1);
    mode_en <= 1'b1;
    n = 0;
    while (gstat !== 1'b1 && n < 9000) begin @(posedge clk); n++; end
    // 512 pin rises at 40 ns each is 5120 cycles, plus power and filter latency
    `CHK(n inside {[5100:5150]}, 1'b1)
    `CHK(fpwr, 1'b1)
    rd(xosc_pkg::FAST_CTL_OFS, 32'h000000e0, ctl(0, 0, 0, 1, 1, 0) | 32'h40, 0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    // Masking, then write 0 and write 1 to the pending flag
    wr(xosc_pkg::FAST_CTL_OFS, ctl(0, 1, 0, 0, 0, 0));
    wr(xosc_pkg::IRQ_MASK_OFS, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(xosc_pkg::FAST_CTL_OFS, ctl(0, 1, 1, 0, 0, 0));
    wr(xosc_pkg::IRQ_MASK_OFS, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(xosc_pkg::FAST_CTL_OFS, ctl(0, 1, 1, 1, 0, 0));
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(xosc_pkg::FAST_CTL_OFS, 32'h00000080, 32'h0, 0);
    // Random divider factor
    div = $urandom_range(31, 1);
    wr(xosc_pkg::FAST_CTL_OFS, ctl(0, 1, 1, 0, 0, div[4:0]));
    measure((div + 1) * 8);
    `CHK(cnt inside {[7:9]}, 1'b1)
    // Power down by mode, then restart
    mode_en <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK({fpwr, gstat, fclk}, 3'b000)
    mode_en <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(gstat, 1'b0)
    // Slow oscillator switched by its own power bit
    wr(xosc_pkg::SLOW_CTL_OFS, ctl(0, 1, 0, 0, 1, 0));
    repeat (20) @(posedge clk);
    `CHK(spwr, 1'b1)
    rd(xosc_pkg::SLOW_CTL_OFS, 32'h00000060, 32'h00000020, 0);
    n = 0;
    while (sclk !== 1'b1 && n < 12000) begin @(posedge clk); n++; end
    // 512 pin rises at 64 ns each, less the cycles already spent since power on
    `CHK(n inside {[8140:8200]}, 1'b1)
    rd(xosc_pkg::SLOW_CTL_OFS, 32'h00000060, 32'h00000060, 0);
    // Both pending bits stand; clearing the slow one leaves the fast one
    rd(xosc_pkg::IRQ_STAT_OFS, 32'h00000003, 32'h00000003, 0);
    wr(xosc_pkg::IRQ_STAT_OFS, 32'h00000002);
    rd(xosc_pkg::IRQ_STAT_OFS, 32'h00000003, 32'h00000001, 0);
    // Fast bypass with an external clock, then a refused clear
    wr(xosc_pkg::FAST_CTL_OFS, ctl(1, 1, 1, 0, 0, 0));
    byp_f <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK({fpwr, gstat}, 2'b01)
    measure(16);
    `CHK(cnt inside {[15:17]}, 1'b1)
    mode_en <= 1'b0;
    wr(xosc_pkg::FAST_CTL_OFS, ctl(0, 1, 1, 0, 0, 0));
    rd(xosc_pkg::FAST_CTL_OFS, 32'h80000040, 32'h80000040, 0);
    wr(xosc_pkg::SLOW_CTL_OFS, ctl(1, 1, 0, 0, 0, 0));
    byp_s <= 1'b1;
    rd(xosc_pkg::SLOW_CTL_OFS, 32'h80000060, 32'h80000040, 0);
    // Second reset clears bypass
    rst_n <= 1'b0; byp_f <= 1'b0; byp_s <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(xosc_pkg::FAST_CTL_OFS, 32'h80000060, 32'h0, 0);
    rd(xosc_pkg::SLOW_CTL_OFS, 32'h80000060, 32'h0, 0);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
